// >>> bench/tb.sv
// self-checking bench for the time base and dual timer block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_n, sleep_req, hold_req, rate_port_we, warmup_tick, instr_clk, osc_output_pin;
  logic        phase_one, phase_two, phase_three, phase_four, periodic_tick_req, latch_periodic_tick_set;
  logic        timer_a_overflow_req, timer_b_overflow_req, latch_timer_a_set, latch_timer_b_set;
  logic [3:0]  rate_port_wdata, timebase_irq_rate_port, timer_a_rd_data, timer_b_rd_data;
  logic [1:0]  timer_a_rd_sel, timer_b_rd_sel, warmup_sel;
  logic [11:0] timer_a_count, timer_b_count, v;
  tbt_pkg::tbt_timer_wr_t timer_a_wr, timer_b_wr;
  int          n_a, n_b, n_t, n_errors, tests_run, seed, c, n, e, p;
  int          te[4] = '{tbt_pkg::TBI_EXP_L0, tbt_pkg::TBI_EXP_L1, tbt_pkg::TBI_EXP_L2, tbt_pkg::TBI_EXP_L3};
  int          me[4] = '{tbt_pkg::TMR_EXP_0, tbt_pkg::TMR_EXP_1, tbt_pkg::TMR_EXP_2, tbt_pkg::TMR_EXP_3};

  tbt_top dut (.*);
  tbt_irq_model irq (.sys_clk(sys_clk), .rst_n(rst_n), .set_a(latch_timer_a_set), .set_b(latch_timer_b_set),
    .set_t(latch_periodic_tick_set), .n_a(n_a), .n_b(n_b), .n_t(n_t));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", w, x, g);
    end
  endtask

  // bounded wait on one request line; n holds the cycles taken
  task automatic wait_ev(input int s, input int lim);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n > lim) begin
        n_errors++;
        $display("[ERR] event %0d expected by %0d seen none", s, lim);
        summarize();
      end
    end while ((s == 0 ? periodic_tick_req : s == 1 ? timer_a_overflow_req :
                s == 2 ? timer_b_overflow_req : warmup_tick) !== 1'b1);
  endtask

  task automatic wr_rate(input logic [3:0] d);
    @(posedge sys_clk);
    rate_port_we <= 1'b1;
    rate_port_wdata <= d;
    @(posedge sys_clk);
    rate_port_we <= 1'b0;
    @(negedge sys_clk);
  endtask

  // same write to both timers, so they start on the same tap edge
  task automatic tmr_wr(input logic cmd, input logic [1:0] sel, input logic [3:0] d);
    @(posedge sys_clk);
    timer_a_wr <= '{cmd, d, !cmd, sel, d};
    timer_b_wr <= '{cmd, d, !cmd, sel, d};
    @(posedge sys_clk);
    {timer_a_wr, timer_b_wr} <= '0;
  endtask

  initial begin
    seed = 11;
    {rst_n, sleep_req, hold_req, rate_port_we, rate_port_wdata, timer_a_rd_sel, timer_b_rd_sel} = '0;
    {timer_a_wr, timer_b_wr} = '0;
    warmup_sel = 2'h3;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("reset", {tbt_pkg::RATE_PORT_RESET, 12'h000, 4'h1},
        {timebase_irq_rate_port, timer_a_count, phase_four, phase_three, phase_two, phase_one});
    chk("reset b", {12'h000, 1'b1, 1'b0}, {timer_b_count, instr_clk, osc_output_pin});
    // every rate code: readback, silence when off, low bank period measured
    for (int k = 0; k < 16; k++) begin
      wr_rate(4'(k));
      chk("rate port", k, timebase_irq_rate_port);
      c = n_t;
      if (k[2] == 1'b0) begin
        repeat (600) @(negedge sys_clk);
        chk("silent ticks", c, n_t);
      end else if (k < 8) begin
        e = te[k[1:0]];
        wait_ev(0, (1 << e) + 8);
        wait_ev(0, (1 << e) + 8);
        chk("tick period", 1 << e, n);
        @(negedge sys_clk);
        chk("tick latch", c + 2, n_t);
      end
    end
    // sleep then hold: the time base restarts from zero on wake
    wr_rate(4'h4);
    for (int s = 0; s < 2; s++) begin
      wait_ev(0, 600);
      @(posedge sys_clk);
      sleep_req <= (s == 0);
      hold_req <= (s == 1);
      repeat (20) @(posedge sys_clk);
      if (s == 0) chk("osc pin", 1, osc_output_pin);
      {sleep_req, hold_req} <= 2'b00;
      wait_ev(0, 300);
      chk("wake tick", 1, n > 250 && n < 262);
    end
    // high bank tick and warm-up strobe, both timed from a time base cleared by sleep
    @(posedge sys_clk);
    sleep_req <= 1'b1;
    warmup_sel <= 2'h1;
    wr_rate(4'hC);
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    wait_ev(3, 4200);
    chk("warm-up strobe", (1 << (tbt_pkg::TBI_EXP_L3 - 1)) + 2, n);
    wait_ev(0, 4200);
    chk("high bank tick", (1 << (tbt_pkg::TBI_EXP_H0 - 1)) - (1 << (tbt_pkg::TBI_EXP_L3 - 1)), n);
    // per pulse rate: random pulse count, nibble readback, run to overflow
    for (int r = 0; r < 4; r++) begin
      p = r == 3 ? 1 : 1 + $unsigned($random(seed)) % 3;
      v = 12'(13'h1000 - p);
      for (int s = 0; s < 3; s++) tmr_wr(1'b0, 2'(s), v[4*s+:4]);
      for (int s = 0; s < 4; s++) begin
        @(posedge sys_clk);
        timer_a_rd_sel <= 2'(s);
        timer_b_rd_sel <= 2'(3 - s);
        @(negedge sys_clk);
        chk("a nibble", s < 3 ? v[4*s+:4] : 4'h0, timer_a_rd_data);
        chk("b nibble", s > 0 ? v[12-4*s+:4] : 4'h0, timer_b_rd_data);
      end
      c = n_a + n_b;
      tmr_wr(1'b1, 2'h0, 4'h8 | 4'(r));
      e = me[r];
      wait_ev(1, (p << e) + 8);
      chk("a overflow cycle", 1, n > (p - 1) << e);
      chk("b overflow too", 1, timer_b_overflow_req);
      @(negedge sys_clk);
      chk("latch count", c + 2, n_a + n_b);
      tmr_wr(1'b1, 2'h0, 4'h0);
    end
    summarize();
  end
endmodule

// >>> bench/tbt_irq_model.sv
// interrupt controller model: counts each latch setting
module tbt_irq_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic set_a,
  input  wire logic set_b,
  input  wire logic set_t,
  output int        n_a,
  output int        n_b,
  output int        n_t
);
  // latches are set by hardware pulses only, never by software
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      n_a <= 0;
      n_b <= 0;
      n_t <= 0;
    end else begin
      n_a <= n_a + int'(set_a);
      n_b <= n_b + int'(set_b);
      n_t <= n_t + int'(set_t);
    end
  end
endmodule

// >>> bench/tbt_monitor.sv
// assertion checker for the time base and dual timer block
module tbt_monitor #(
  parameter int CNT_W = tbt_pkg::CNT_W
) (
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire logic                   sleep_req,
  input wire logic                   hold_req,
  input wire tbt_pkg::tbt_timer_wr_t timer_a_wr,
  input wire logic [3:0]             timebase_irq_rate_port,
  input wire logic [CNT_W-1:0]       timer_a_count,
  input wire logic                   phase_one,
  input wire logic                   phase_two,
  input wire logic                   phase_three,
  input wire logic                   phase_four,
  input wire logic                   instr_clk,
  input wire logic                   osc_output_pin,
  input wire logic                   timer_a_overflow_req,
  input wire logic                   timer_b_overflow_req,
  input wire logic                   periodic_tick_req,
  input wire logic                   latch_timer_a_set,
  input wire logic                   latch_timer_b_set,
  input wire logic                   latch_periodic_tick_set
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // phase ring as one vector; sleep and hold both freeze it
  wire logic [3:0] ph   = {phase_four, phase_three, phase_two, phase_one};
  wire logic       halt = sleep_req | hold_req;
  // the release edge still shows reset values, so attempts start once rst_n is sampled high
  phase_step_a: assert property (rst_n && !halt |=> ph == {$past(ph[2:0]), $past(ph[3])})
    else $error("phase ring did not step");
  instr_len_a: assert property (rst_n && phase_one ##0 !halt [*4] |=> phase_one)
    else $error("instruction cycle not four clocks");
  halt_freeze_a: assert property (halt && !timer_a_wr.nib_we |=> $stable(ph) && $stable(timer_a_count))
    else $error("activity while halted");
  osc_high_a: assert property (sleep_req |=> osc_output_pin)
    else $error("osc pin low in sleep");
  osc_run_a: assert property (rst_n && !sleep_req |=> osc_output_pin != $past(osc_output_pin))
    else $error("osc pin stuck while awake");
  wrap_zero_a: assert property (timer_a_overflow_req |-> timer_a_count == '0 && $past(timer_a_count) == '1)
    else $error("overflow without wrap");
  count_step_a: assert property ($changed(timer_a_count) && !$past(timer_a_wr.nib_we)
    |-> timer_a_count == $past(timer_a_count) + 1'b1)
    else $error("count moved by other than one");
  tick_off_a: assert property (!timebase_irq_rate_port[2] && !$past(timebase_irq_rate_port[2]) |-> !periodic_tick_req)
    else $error("tick while disabled");
  tick_pulse_a: assert property (periodic_tick_req |=> !periodic_tick_req)
    else $error("tick longer than one cycle");
  sys_clock_a: assert property (instr_clk == (phase_one || phase_two))
    else $error("system clock not high in first two phases");
  latch_map_a: assert property ({latch_timer_a_set, latch_timer_b_set, latch_periodic_tick_set}
    == {timer_a_overflow_req, timer_b_overflow_req, periodic_tick_req})
    else $error("latch set differs from request");
  cover property (timer_a_overflow_req);
  cover property (periodic_tick_req);
  cover property (sleep_req ##1 !sleep_req);
endmodule

bind tbt_top tbt_monitor #(.CNT_W(CNT_W)) u_mon (.*);

// >>> core/tbt_pkg.sv
// package for the time base and dual timer block
package tbt_pkg;
  localparam int TB_STAGES  = 22;
  localparam int CNT_W      = 12;
  localparam int NIB_W      = 4;
  localparam int PHASES     = 4;
  localparam logic [3:0] RATE_PORT_RESET = 4'h0;
  localparam logic [3:0] CMD_PORT_RESET  = 4'h0;
  localparam logic [1:0] TBI_DISABLED    = 2'h0;
  localparam logic [1:0] TBI_LOW_BANK    = 2'h1;
  localparam logic [1:0] TBI_RESERVED    = 2'h2;
  localparam logic [1:0] TBI_HIGH_BANK   = 2'h3;
  // divider exponents: time-base taps for tick rates
  localparam int TBI_EXP_L0 = 9;
  localparam int TBI_EXP_L1 = 10;
  localparam int TBI_EXP_L2 = 12;
  localparam int TBI_EXP_L3 = 13;
  localparam int TBI_EXP_H0 = 14;
  localparam int TBI_EXP_H1 = 15;
  localparam int TBI_EXP_H2 = 16;
  localparam int TBI_EXP_H3 = 17;
  // divider exponents for timer count pulses
  localparam int TMR_EXP_0 = 5;
  localparam int TMR_EXP_1 = 7;
  localparam int TMR_EXP_2 = 11;
  localparam int TMR_EXP_3 = 15;
  localparam int CMD_RUN_BIT = 3;
  // nibble selects for timer count registers
  localparam logic [1:0] NIB_LOW  = 2'h0;
  localparam logic [1:0] NIB_MID  = 2'h1;
  localparam logic [1:0] NIB_HIGH = 2'h2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;

  typedef enum logic [3:0] {
    TBT_PH1 = 4'b0001,
    TBT_PH2 = 4'b0010,
    TBT_PH3 = 4'b0100,
    TBT_PH4 = 4'b1000
  } tbt_phase_t;

  // cpu write strobe group for one timer
  typedef struct packed {
    logic             cmd_we;
    logic [NIB_W-1:0] cmd_data;
    logic             nib_we;
    logic [1:0]       nib_sel;
    logic [NIB_W-1:0] nib_data;
  } tbt_timer_wr_t;
endpackage

// >>> core/tbt_timer.sv
// one 12-bit up-counting timer with command port and nibble preset
module tbt_timer #(
  parameter int CNT_W = tbt_pkg::CNT_W
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      sleep_hold,
  input  wire tbt_pkg::tbt_timer_wr_t    wr,
  input  wire logic [3:0]                pulse_taps,
  input  wire logic [1:0]                rd_sel,
  output logic [tbt_pkg::NIB_W-1:0]      rd_data,
  output logic [CNT_W-1:0]               count,
  output logic                           overflow_req
);
  typedef struct packed {
    logic [3:0]       cmd;
    logic [CNT_W-1:0] cnt;
    logic             tap_d;
    logic             ovf;
  } tbt_tmr_state_t;

  tbt_tmr_state_t state_reg;
  tbt_tmr_state_t state_next;
  logic           tap;
  logic           rise;

  // rate field picks one time-base tap
  assign tap  = pulse_taps[state_reg.cmd[1:0]];
  assign rise = tap & ~state_reg.tap_d;

  // count, preset and overflow next-state
  always_comb begin
    state_next       = state_reg;
    state_next.ovf   = 1'b0;
    if (wr.cmd_we) begin
      state_next.cmd = wr.cmd_data;
    end
    // follow the tap of the rate in force next cycle, so a rate change is no edge
    state_next.tap_d = pulse_taps[state_next.cmd[1:0]];
    // preset takes priority over a pulse in the same cycle
    if (wr.nib_we) begin
      case (wr.nib_sel)
        tbt_pkg::NIB_LOW:  state_next.cnt[3:0]  = wr.nib_data;
        tbt_pkg::NIB_MID:  state_next.cnt[7:4]  = wr.nib_data;
        tbt_pkg::NIB_HIGH: state_next.cnt[11:8] = wr.nib_data;
        default:           state_next.cnt       = state_reg.cnt;
      endcase
    end else if (state_reg.cmd[tbt_pkg::CMD_RUN_BIT] && rise && !sleep_hold) begin
      state_next.cnt = state_reg.cnt + tbt_pkg::CNT_ONE;
      state_next.ovf = (state_reg.cnt == {CNT_W{1'b1}});
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg.cmd   <= tbt_pkg::CMD_PORT_RESET;
      state_reg.cnt   <= tbt_pkg::CNT_ZERO;
      state_reg.tap_d <= 1'b0;
      state_reg.ovf   <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // readback of live count nibbles
  always_comb begin
    case (rd_sel)
      tbt_pkg::NIB_LOW:  rd_data = state_reg.cnt[3:0];
      tbt_pkg::NIB_MID:  rd_data = state_reg.cnt[7:4];
      tbt_pkg::NIB_HIGH: rd_data = state_reg.cnt[11:8];
      default:           rd_data = 4'h0;
    endcase
  end

  assign count        = state_reg.cnt;
  assign overflow_req = state_reg.ovf;
endmodule

// >>> core/tbt_top.sv
// clock phase generator, 22-stage time base and two timers
// Contract
// - instruction cycle spans exactly four core clock periods
// - four one-hot phase signals, one per core period, plus system clock
// - sleep freezes the phase ring and timer counting until released
// - oscillator output pin held high during sleep
// - 22-stage binary time base clocked by the core clock
// - taps feed tick interrupt, timer pulses and wake warm-up
// - periodic tick request at rate chosen by the rate-select port
// - rate port resets to 0000; upper 00 off, 10 reserved
// - upper 01 selects divide by 2^9, 2^10, 2^12, 2^13
// - upper 11 selects divide by 2^14, 2^15, 2^16, 2^17
// - two independent timers count internal pulses only
// - high, mid, low nibble registers preset and read each count
// - each timer has its own command port selecting pulse rate
// - running timer increments on each rising edge of its pulse
// - rate field 00/01/10/11 selects divide by 2^5, 2^7, 2^11, 2^15
// - command bit 3 runs the timer, bits 1:0 choose rate
// - counting past maximum sends that timer's overflow request
// - entering sleep or hold clears the time base to zero
// - timer A and B overflows set separate interrupt latches
// - periodic tick request sets its own interrupt latch
module tbt_top #(
  parameter int TB_STAGES = tbt_pkg::TB_STAGES,
  parameter int CNT_W     = tbt_pkg::CNT_W
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    sleep_req,
  input  wire logic                    hold_req,
  input  wire logic                    rate_port_we,
  input  wire logic [3:0]              rate_port_wdata,
  output logic [3:0]                   timebase_irq_rate_port,
  input  wire tbt_pkg::tbt_timer_wr_t  timer_a_wr,
  input  wire tbt_pkg::tbt_timer_wr_t  timer_b_wr,
  input  wire logic [1:0]              timer_a_rd_sel,
  input  wire logic [1:0]              timer_b_rd_sel,
  output logic [3:0]                   timer_a_rd_data,
  output logic [3:0]                   timer_b_rd_data,
  output logic [CNT_W-1:0]             timer_a_count,
  output logic [CNT_W-1:0]             timer_b_count,
  input  wire logic [1:0]              warmup_sel,
  output logic                         warmup_tick,
  output logic                         phase_one,
  output logic                         phase_two,
  output logic                         phase_three,
  output logic                         phase_four,
  output logic                         instr_clk,
  output logic                         osc_output_pin,
  output logic                         timer_a_overflow_req,
  output logic                         timer_b_overflow_req,
  output logic                         periodic_tick_req,
  output logic                         latch_timer_a_set,
  output logic                         latch_timer_b_set,
  output logic                         latch_periodic_tick_set
);
  typedef struct packed {
    tbt_pkg::tbt_phase_t   phase;
    logic [TB_STAGES-1:0]  tb;
    logic [3:0]            rate;
    logic                  tick_tap_d;
    logic                  tick;
    logic                  warm_tap_d;
    logic                  warm;
    logic                  osc_out;
  } tbt_state_t;

  tbt_state_t state_reg;
  tbt_state_t state_next;
  logic       sleep_hold;
  logic       tick_tap;
  logic       tick_on;
  logic       warm_tap;
  logic [3:0] timer_taps;

  // tap of divide by 2^n is time-base bit n-1
  function automatic logic tb_tap(input logic [TB_STAGES-1:0] tb, input int exp_n);
    tb_tap = tb[exp_n-1];
  endfunction

  assign sleep_hold = sleep_req | hold_req;

  // rate-select decode; reserved and disabled codes give no tick
  always_comb begin
    tick_on  = 1'b1;
    tick_tap = 1'b0;
    case (state_reg.rate[3:2])
      tbt_pkg::TBI_LOW_BANK: begin
        case (state_reg.rate[1:0])
          2'h0:    tick_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_L0);
          2'h1:    tick_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_L1);
          2'h2:    tick_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_L2);
          default: tick_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_L3);
        endcase
      end
      tbt_pkg::TBI_HIGH_BANK: begin
        case (state_reg.rate[1:0])
          2'h0:    tick_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_H0);
          2'h1:    tick_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_H1);
          2'h2:    tick_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_H2);
          default: tick_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_H3);
        endcase
      end
      default: tick_on = 1'b0;
    endcase
  end

  // warm-up interval taps, same encoding as the sleep control field
  always_comb begin
    case (warmup_sel)
      2'h0:    warm_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_H3);
      2'h1:    warm_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_L3);
      2'h2:    warm_tap = tb_tap(state_reg.tb, tbt_pkg::TBI_EXP_H1);
      default: warm_tap = 1'b0;
    endcase
  end

  // timer pulse taps indexed by rate field
  assign timer_taps = {tb_tap(state_reg.tb, tbt_pkg::TMR_EXP_3),
                       tb_tap(state_reg.tb, tbt_pkg::TMR_EXP_2),
                       tb_tap(state_reg.tb, tbt_pkg::TMR_EXP_1),
                       tb_tap(state_reg.tb, tbt_pkg::TMR_EXP_0)};

  // phase ring, time base and tick detection
  always_comb begin
    state_next      = state_reg;
    state_next.tick = 1'b0;
    state_next.warm = 1'b0;
    if (rate_port_we) begin
      state_next.rate = rate_port_wdata;
    end
    if (sleep_hold) begin
      // hold keeps clocks in real silicon; here both freeze the phase ring
      state_next.tb         = '0;
      state_next.tick_tap_d = 1'b0;
      state_next.warm_tap_d = 1'b0;
      state_next.osc_out    = sleep_req ? 1'b1 : ~state_reg.osc_out;
    end else begin
      state_next.osc_out = ~state_reg.osc_out;
      case (state_reg.phase)
        tbt_pkg::TBT_PH1: state_next.phase = tbt_pkg::TBT_PH2;
        tbt_pkg::TBT_PH2: state_next.phase = tbt_pkg::TBT_PH3;
        tbt_pkg::TBT_PH3: state_next.phase = tbt_pkg::TBT_PH4;
        default:          state_next.phase = tbt_pkg::TBT_PH1;
      endcase
      state_next.tb         = state_reg.tb + {{(TB_STAGES-1){1'b0}}, 1'b1};
      // a new rate would meet the old tap's history; mask one cycle instead
      state_next.tick_tap_d = rate_port_we ? 1'b1 : tick_tap;
      state_next.warm_tap_d = warm_tap;
      state_next.tick       = tick_on & tick_tap & ~state_reg.tick_tap_d;
      state_next.warm       = warm_tap & ~state_reg.warm_tap_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg.phase      <= tbt_pkg::TBT_PH1;
      state_reg.tb         <= '0;
      state_reg.rate       <= tbt_pkg::RATE_PORT_RESET;
      state_reg.tick_tap_d <= 1'b0;
      state_reg.tick       <= 1'b0;
      state_reg.warm_tap_d <= 1'b0;
      state_reg.warm       <= 1'b0;
      state_reg.osc_out    <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // timers share the time base and the sleep_hold gate but nothing else
  tbt_timer #(.CNT_W(CNT_W)) u_timer_a (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sleep_hold   (sleep_hold),
    .wr           (timer_a_wr),
    .pulse_taps   (timer_taps),
    .rd_sel       (timer_a_rd_sel),
    .rd_data      (timer_a_rd_data),
    .count        (timer_a_count),
    .overflow_req (timer_a_overflow_req)
  );

  tbt_timer #(.CNT_W(CNT_W)) u_timer_b (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sleep_hold   (sleep_hold),
    .wr           (timer_b_wr),
    .pulse_taps   (timer_taps),
    .rd_sel       (timer_b_rd_sel),
    .rd_data      (timer_b_rd_data),
    .count        (timer_b_count),
    .overflow_req (timer_b_overflow_req)
  );

  // outputs; latch set strobes mirror the request pulses
  assign phase_one               = state_reg.phase[0];
  assign phase_two               = state_reg.phase[1];
  assign phase_three             = state_reg.phase[2];
  assign phase_four              = state_reg.phase[3];
  assign instr_clk               = state_reg.phase[0] | state_reg.phase[1];
  assign osc_output_pin          = state_reg.osc_out;
  assign timebase_irq_rate_port  = state_reg.rate;
  assign periodic_tick_req       = state_reg.tick;
  assign warmup_tick             = state_reg.warm;
  assign latch_timer_a_set       = timer_a_overflow_req;
  assign latch_timer_b_set       = timer_b_overflow_req;
  assign latch_periodic_tick_set = state_reg.tick;
endmodule
